// ===== verilog/hcg_regs.vh
// Register offsets, field positions, reset values and timing constants of the horizontal clock generator.
`ifndef HCG_REGS_VH
`define HCG_REGS_VH
`define HCG_REG_CTRL        8'h00
`define HCG_REG_ODD_EDGE    8'h04
`define HCG_REG_RG_EDGE     8'h08
`define HCG_REG_HL_EDGE     8'h0C
`define HCG_REG_SAMPLE      8'h10
`define HCG_REG_DRIVE       8'h14
`define HCG_REG_TOG0        8'h18
`define HCG_REG_TOG1        8'h1C
`define HCG_REG_TOG2        8'h20
`define HCG_REG_LINE        8'h24
`define HCG_REG_LOAD        8'h28
`define HCG_REG_STATUS      8'h2C
`define HCG_CTRL_ODD_POL    0
`define HCG_CTRL_RG_POL     1
`define HCG_CTRL_BLK_LVL    2
`define HCG_CTRL_ENABLE     3
`define HCG_RISE_LSB        0
`define HCG_FALL_LSB        8
`define HCG_SHP_LSB         0
`define HCG_SHD_LSB         8
`define HCG_DRV_ODD_LSB     0
`define HCG_DRV_EVEN_LSB    4
`define HCG_DRV_RG_LSB      8
`define HCG_DRV_HL_LSB      12
`define HCG_TOG_START_LSB   0
`define HCG_TOG_END_LSB     16
`define HCG_RST_CTRL        32'h0000_0000
`define HCG_RST_ODD_EDGE    32'h0000_2000
`define HCG_RST_RG_EDGE     32'h0000_1000
`define HCG_RST_HL_EDGE     32'h0000_2000
`define HCG_RST_SAMPLE      32'h0000_0020
`define HCG_RST_DRIVE       32'h0000_0000
`define HCG_RST_TOG         32'h0000_0000
`define HCG_RST_LINE        32'h0000_0FFF
`define HCG_STEPS           48
`define HCG_QUAD_SPAN       12
`define HCG_CODE_UNMAPPED   32'hDEAD_BEEF
`endif

// ===== verilog/hcg_edge_wave.v
// One sub-pixel waveform: rise and fall codes turned into a 48-bit per-period pattern.
`timescale 1ns/1ps
module hcg_edge_wave (
  // Edge codes
  input  wire [5:0]  rise_code,
  input  wire [5:0]  fall_code,
  input  wire        invert,
  // Pattern, bit k is the level during sub-step k
  output reg  [47:0] pattern
);
  `include "hcg_regs.vh"
  reg [5:0] rise_pos;
  reg [5:0] fall_pos;
  reg       lvl;
  integer   k;
  always @* begin
    // Upper two bits pick a quadrant of twelve, lower four bits the step inside it.
    rise_pos = {rise_code[5:4], 4'h0} - {2'h0, rise_code[5:4], 2'h0} + {2'h0, rise_code[3:0]};
    fall_pos = {fall_code[5:4], 4'h0} - {2'h0, fall_code[5:4], 2'h0} + {2'h0, fall_code[3:0]};
    lvl = (fall_pos < rise_pos);
    for (k = 0; k < `HCG_STEPS; k = k + 1) begin
      if (k[5:0] == rise_pos) begin
        lvl = 1'b1;
      end else if (k[5:0] == fall_pos) begin
        lvl = 1'b0;
      end
      pattern[k] = lvl ^ invert;
    end
  end
endmodule // hcg_edge_wave

// ===== verilog/hcg_top.v
// Horizontal CCD clock generator with AXI4-Lite configuration.
// Functional notes
// - Horizontal phases take a 4-bit drive code, 4.3 mA per step, 64.5 mA max.
// - Horizontal drive code zero switches those outputs to high impedance.
// - Reset gate and last stage take 3-bit codes, 2.2 mA steps; zero is off.
// - Phases two and four are always the inverse of phases one and three.
// - Polarity bits invert odd phases and reset gate outputs, one bit each, when set.
// - Rising edge of odd phases and reset gate at a 6-bit position 0-47.
// - Falling edge at a separate 6-bit position 0-47.
// - Reference and data sample strobes each placed at a 6-bit position 0-47.
// - Each master clock period splits into 48 equal sub-steps.
// - Edge codes are four quadrants of twelve; low four bits 0 to 11.
// - Blanking windows are bounded by start and end toggle positions; the line end also closes an open window.
// - With level select high, blanking forces odd phases high, even phases low.
// - Up to three blanking windows per line, processed from window zero.
// - Settings written in one burst take effect together at the load strobe.
`timescale 1ns/1ps
module hcg_top (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Sub-step patterns for the high speed serialiser, bit k is sub-step k
  output reg  [47:0] horizontal_phase_one,
  output reg  [47:0] horizontal_phase_two,
  output reg  [47:0] horizontal_phase_three,
  output reg  [47:0] horizontal_phase_four,
  output reg  [47:0] reset_gate_out_a,
  output reg  [47:0] reset_gate_out_b,
  output reg  [47:0] last_stage_horizontal_clock,
  output reg  [47:0] reference_sample_strobe,
  output reg  [47:0] data_sample_strobe,
  // Output enables and drive codes of the pin drivers
  output reg         odd_phase_oe,
  output reg         even_phase_oe,
  output reg         reset_gate_oe,
  output reg         last_stage_oe,
  output reg  [3:0]  odd_phase_drive_code,
  output reg  [3:0]  even_phase_drive_code,
  output reg  [2:0]  reset_gate_drive_code,
  output reg  [2:0]  last_stage_drive_code,
  // Line timing
  output reg         horizontal_blanking,
  output reg  [15:0] pixel_count
);
  `include "hcg_regs.vh"

  // Shadow registers written by software.
  reg  [31:0] sh_ctrl, sh_odd, sh_rg, sh_hl, sh_smp, sh_drv, sh_tog0, sh_tog1, sh_tog2, sh_line;
  // Active registers used by the generator.
  reg  [31:0] ac_ctrl, ac_odd, ac_rg, ac_hl, ac_smp, ac_drv, ac_tog0, ac_tog1, ac_tog2, ac_line;
  reg         load_pend;
  reg  [15:0] load_count;

  // AXI write channel: address and data may arrive in either order.
  reg         aw_held;
  reg  [7:0]  aw_addr;
  reg         w_held;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  wire        do_write;
  wire [7:0]  wr_addr;
  wire [31:0] wr_data;
  wire [3:0]  wr_strb;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_addr  = aw_held ? aw_addr : s_axi_awaddr;
  assign wr_data  = w_held ? w_data : s_axi_wdata;
  assign wr_strb  = w_held ? w_strb : s_axi_wstrb;
  assign do_write = (aw_held || (s_axi_awvalid && s_axi_awready)) &&
                    (w_held || (s_axi_wvalid && s_axi_wready));

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  st;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (st[b]) begin
          merge[b*8 +: 8] = nw[b*8 +: 8];
        end
      end
    end
  endfunction

  reg wr_hit;
  always @* begin
    case (wr_addr)
      `HCG_REG_CTRL, `HCG_REG_ODD_EDGE, `HCG_REG_RG_EDGE, `HCG_REG_HL_EDGE, `HCG_REG_SAMPLE,
      `HCG_REG_DRIVE, `HCG_REG_TOG0, `HCG_REG_TOG1, `HCG_REG_TOG2, `HCG_REG_LINE,
      `HCG_REG_LOAD: wr_hit = 1'b1;
      default:       wr_hit = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      aw_addr      <= 8'h00;
      w_held       <= 1'b0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      sh_ctrl      <= `HCG_RST_CTRL;
      sh_odd       <= `HCG_RST_ODD_EDGE;
      sh_rg        <= `HCG_RST_RG_EDGE;
      sh_hl        <= `HCG_RST_HL_EDGE;
      sh_smp       <= `HCG_RST_SAMPLE;
      sh_drv       <= `HCG_RST_DRIVE;
      sh_tog0      <= `HCG_RST_TOG;
      sh_tog1      <= `HCG_RST_TOG;
      sh_tog2      <= `HCG_RST_TOG;
      sh_line      <= `HCG_RST_LINE;
      load_pend    <= 1'b0;
    end else begin
      load_pend <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? 2'h0 : 2'h2;
        case (wr_addr)
          `HCG_REG_CTRL:     sh_ctrl <= merge(sh_ctrl, wr_data, wr_strb);
          `HCG_REG_ODD_EDGE: sh_odd  <= merge(sh_odd, wr_data, wr_strb);
          `HCG_REG_RG_EDGE:  sh_rg   <= merge(sh_rg, wr_data, wr_strb);
          `HCG_REG_HL_EDGE:  sh_hl   <= merge(sh_hl, wr_data, wr_strb);
          `HCG_REG_SAMPLE:   sh_smp  <= merge(sh_smp, wr_data, wr_strb);
          `HCG_REG_DRIVE:    sh_drv  <= merge(sh_drv, wr_data, wr_strb);
          `HCG_REG_TOG0:     sh_tog0 <= merge(sh_tog0, wr_data, wr_strb);
          `HCG_REG_TOG1:     sh_tog1 <= merge(sh_tog1, wr_data, wr_strb);
          `HCG_REG_TOG2:     sh_tog2 <= merge(sh_tog2, wr_data, wr_strb);
          `HCG_REG_LINE:     sh_line <= merge(sh_line, wr_data, wr_strb);
          `HCG_REG_LOAD:     load_pend <= wr_strb[0] & wr_data[0];
          default:           load_pend <= 1'b0;
        endcase
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_held <= 1'b1;
          aw_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_held <= 1'b1;
          w_data <= s_axi_wdata;
          w_strb <= s_axi_wstrb;
        end
      end
    end
  end

  // The load strobe copies every shadow at once, so a half-written set never reaches the pins.
  always @(posedge aclk) begin
    if (!aresetn) begin
      ac_ctrl    <= `HCG_RST_CTRL;
      ac_odd     <= `HCG_RST_ODD_EDGE;
      ac_rg      <= `HCG_RST_RG_EDGE;
      ac_hl      <= `HCG_RST_HL_EDGE;
      ac_smp     <= `HCG_RST_SAMPLE;
      ac_drv     <= `HCG_RST_DRIVE;
      ac_tog0    <= `HCG_RST_TOG;
      ac_tog1    <= `HCG_RST_TOG;
      ac_tog2    <= `HCG_RST_TOG;
      ac_line    <= `HCG_RST_LINE;
      load_count <= 16'h0000;
    end else if (load_pend) begin
      ac_ctrl    <= sh_ctrl;
      ac_odd     <= sh_odd;
      ac_rg      <= sh_rg;
      ac_hl      <= sh_hl;
      ac_smp     <= sh_smp;
      ac_drv     <= sh_drv;
      ac_tog0    <= sh_tog0;
      ac_tog1    <= sh_tog1;
      ac_tog2    <= sh_tog2;
      ac_line    <= sh_line;
      load_count <= load_count + 16'h0001;
    end
  end

  // AXI read channel, answered one cycle after the address is taken.
  reg [31:0] rd_mux;
  reg        rd_hit;
  reg [1:0]  blk_index;
  assign s_axi_arready = !s_axi_rvalid;
  always @* begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `HCG_REG_CTRL:     rd_mux = sh_ctrl;
      `HCG_REG_ODD_EDGE: rd_mux = sh_odd;
      `HCG_REG_RG_EDGE:  rd_mux = sh_rg;
      `HCG_REG_HL_EDGE:  rd_mux = sh_hl;
      `HCG_REG_SAMPLE:   rd_mux = sh_smp;
      `HCG_REG_DRIVE:    rd_mux = sh_drv;
      `HCG_REG_TOG0:     rd_mux = sh_tog0;
      `HCG_REG_TOG1:     rd_mux = sh_tog1;
      `HCG_REG_TOG2:     rd_mux = sh_tog2;
      `HCG_REG_LINE:     rd_mux = sh_line;
      `HCG_REG_LOAD:     rd_mux = 32'h0000_0000;
      `HCG_REG_STATUS:   rd_mux = {load_count, 2'h0, blk_index, horizontal_blanking, 11'h000};
      default: begin
        rd_mux = `HCG_CODE_UNMAPPED;
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_hit ? rd_mux : 32'h0000_0000;
      s_axi_rresp  <= rd_hit ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Pixel counter and blanking windows; windows are walked in order from window zero.
  reg  [15:0] tog_start;
  reg  [15:0] tog_end;
  wire        line_end = (pixel_count == ac_line[15:0]);
  always @* begin
    case (blk_index)
      2'h0:    begin tog_start = ac_tog0[`HCG_TOG_START_LSB +: 16]; tog_end = ac_tog0[`HCG_TOG_END_LSB +: 16]; end
      2'h1:    begin tog_start = ac_tog1[`HCG_TOG_START_LSB +: 16]; tog_end = ac_tog1[`HCG_TOG_END_LSB +: 16]; end
      2'h2:    begin tog_start = ac_tog2[`HCG_TOG_START_LSB +: 16]; tog_end = ac_tog2[`HCG_TOG_END_LSB +: 16]; end
      default: begin tog_start = 16'hFFFF; tog_end = 16'hFFFF; end
    endcase
  end

  // Toggles rely on strictly increasing order; a disordered set skips windows, or with end before start holds one open to the line end.
  always @(posedge aclk) begin
    if (!aresetn || !ac_ctrl[`HCG_CTRL_ENABLE]) begin
      pixel_count         <= 16'h0000;
      blk_index           <= 2'h0;
      horizontal_blanking <= 1'b0;
    end else if (line_end) begin
      pixel_count         <= 16'h0000;
      blk_index           <= 2'h0;
      horizontal_blanking <= 1'b0;
    end else begin
      pixel_count <= pixel_count + 16'h0001;
      if (blk_index != 2'h3) begin
        if (!horizontal_blanking && pixel_count == tog_start && tog_start != tog_end) begin
          horizontal_blanking <= 1'b1;
        end else if (horizontal_blanking && pixel_count == tog_end) begin
          horizontal_blanking <= 1'b0;
          blk_index           <= blk_index + 2'h1;
        end
      end
    end
  end

  // Sub-step waveforms, 48 steps per master clock period.
  wire [47:0] odd_wave, rg_wave, hl_wave, shp_wave, shd_wave;
  hcg_edge_wave u_odd (
    .rise_code (ac_odd[`HCG_RISE_LSB +: 6]),
    .fall_code (ac_odd[`HCG_FALL_LSB +: 6]),
    .invert    (ac_ctrl[`HCG_CTRL_ODD_POL]),
    .pattern   (odd_wave)
  );
  hcg_edge_wave u_rg (
    .rise_code (ac_rg[`HCG_RISE_LSB +: 6]),
    .fall_code (ac_rg[`HCG_FALL_LSB +: 6]),
    .invert    (ac_ctrl[`HCG_CTRL_RG_POL]),
    .pattern   (rg_wave)
  );
  hcg_edge_wave u_hl (
    .rise_code (ac_hl[`HCG_RISE_LSB +: 6]),
    .fall_code (ac_hl[`HCG_FALL_LSB +: 6]),
    .invert    (1'b0),
    .pattern   (hl_wave)
  );
  // A strobe is one sub-step wide: it rises at its code and falls one step later.
  wire [5:0] shp_code = ac_smp[`HCG_SHP_LSB +: 6];
  wire [5:0] shd_code = ac_smp[`HCG_SHD_LSB +: 6];
  wire [5:0] shp_next = (shp_code[3:0] == 4'hB) ? {shp_code[5:4] + 2'h1, 4'h0} : shp_code + 6'h01;
  wire [5:0] shd_next = (shd_code[3:0] == 4'hB) ? {shd_code[5:4] + 2'h1, 4'h0} : shd_code + 6'h01;
  hcg_edge_wave u_shp (
    .rise_code (shp_code),
    .fall_code (shp_next),
    .invert    (1'b0),
    .pattern   (shp_wave)
  );
  hcg_edge_wave u_shd (
    .rise_code (shd_code),
    .fall_code (shd_next),
    .invert    (1'b0),
    .pattern   (shd_wave)
  );

  // Output stage, registered once per master clock period.
  wire [47:0] blk_odd = ac_ctrl[`HCG_CTRL_BLK_LVL] ? 48'hFFFF_FFFF_FFFF : 48'h0000_0000_0000;
  wire [47:0] odd_out = horizontal_blanking ? blk_odd : odd_wave;
  always @(posedge aclk) begin
    if (!aresetn) begin
      horizontal_phase_one        <= 48'h0000_0000_0000;
      horizontal_phase_two        <= 48'hFFFF_FFFF_FFFF;
      horizontal_phase_three      <= 48'h0000_0000_0000;
      horizontal_phase_four       <= 48'hFFFF_FFFF_FFFF;
      reset_gate_out_a            <= 48'h0000_0000_0000;
      reset_gate_out_b            <= 48'h0000_0000_0000;
      last_stage_horizontal_clock <= 48'h0000_0000_0000;
      reference_sample_strobe     <= 48'h0000_0000_0000;
      data_sample_strobe          <= 48'h0000_0000_0000;
      odd_phase_oe                <= 1'b0;
      even_phase_oe               <= 1'b0;
      reset_gate_oe               <= 1'b0;
      last_stage_oe               <= 1'b0;
      odd_phase_drive_code        <= 4'h0;
      even_phase_drive_code       <= 4'h0;
      reset_gate_drive_code       <= 3'h0;
      last_stage_drive_code       <= 3'h0;
    end else begin
      horizontal_phase_one        <= odd_out;
      horizontal_phase_three      <= odd_out;
      horizontal_phase_two        <= ~odd_out;
      horizontal_phase_four       <= ~odd_out;
      reset_gate_out_a            <= rg_wave;
      reset_gate_out_b            <= rg_wave;
      last_stage_horizontal_clock <= hl_wave;
      reference_sample_strobe     <= shp_wave;
      data_sample_strobe          <= shd_wave;
      odd_phase_drive_code        <= ac_drv[`HCG_DRV_ODD_LSB +: 4];
      even_phase_drive_code       <= ac_drv[`HCG_DRV_EVEN_LSB +: 4];
      reset_gate_drive_code       <= ac_drv[`HCG_DRV_RG_LSB +: 3];
      last_stage_drive_code       <= ac_drv[`HCG_DRV_HL_LSB +: 3];
      odd_phase_oe                <= (ac_drv[`HCG_DRV_ODD_LSB +: 4] != 4'h0);
      even_phase_oe               <= (ac_drv[`HCG_DRV_EVEN_LSB +: 4] != 4'h0);
      reset_gate_oe               <= (ac_drv[`HCG_DRV_RG_LSB +: 3] != 3'h0);
      last_stage_oe               <= (ac_drv[`HCG_DRV_HL_LSB +: 3] != 3'h0);
    end
  end
endmodule // hcg_top

// ===== verif/hcg_ccd_model.sv
// Behavioural horizontal register of the sensor, counting charge packets moved.
`timescale 1ns/1ps
module hcg_ccd_model (
  // Clock
  input  logic        aclk,
  // Drive from the generator
  input  logic [47:0] phase_odd,
  input  logic        phase_odd_oe,
  // Packets moved so far
  output logic [15:0] shifts
);
  // A floating phase moves no packet, so shifting needs the driver enabled.
  initial shifts = 16'h0000;
  always @(posedge aclk) begin
    if (phase_odd_oe && (|phase_odd) && !(&phase_odd)) begin
      shifts <= shifts + 16'h0001;
    end
  end
endmodule // hcg_ccd_model

// ===== verif/hcg_chk.sv
// Concurrent checks of the generator outputs and register bus answers.
`timescale 1ns/1ps
module hcg_chk (
  // Clock and reset
  input logic        aclk,
  input logic        aresetn,
  // Bus answers
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic [31:0] s_axi_rdata,
  // Clock outputs
  input logic [47:0] horizontal_phase_one,
  input logic [47:0] horizontal_phase_two,
  input logic [47:0] reset_gate_out_a,
  input logic [47:0] reset_gate_out_b,
  input logic [47:0] reference_sample_strobe,
  input logic        horizontal_blanking,
  // Drivers
  input logic        odd_phase_oe,
  input logic [3:0]  odd_phase_drive_code,
  input logic        reset_gate_oe,
  input logic [2:0]  reset_gate_drive_code
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence blank_held;
    horizontal_blanking ##1 horizontal_blanking;
  endsequence
  sequence wr_waiting;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  even_inverse_a: assert property (horizontal_phase_two == ~horizontal_phase_one)
    else $error("even phase not inverted");
  rg_pair_a: assert property (reset_gate_out_b == reset_gate_out_a)
    else $error("reset gate outputs differ");
  odd_oe_a: assert property (odd_phase_oe == (odd_phase_drive_code != 4'h0))
    else $error("odd driver enable wrong");
  rg_oe_a: assert property (reset_gate_oe == (reset_gate_drive_code != 3'h0))
    else $error("reset gate driver enable wrong");
  shp_onehot_a: assert property ($past(aresetn) |-> $onehot(reference_sample_strobe))
    else $error("reference strobe not one-hot");
  blank_force_a: assert property (blank_held |-> (&horizontal_phase_one || horizontal_phase_one == 48'h0))
    else $error("phase not forced in blanking");
  bresp_hold_a: assert property (wr_waiting |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule // hcg_chk

bind hcg_top hcg_chk u_chk (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .horizontal_phase_one, .horizontal_phase_two, .reset_gate_out_a,
  .reset_gate_out_b, .reference_sample_strobe, .horizontal_blanking, .odd_phase_oe, .odd_phase_drive_code,
  .reset_gate_oe, .reset_gate_drive_code);

// ===== verif/tb.sv
// Self-checking bench: register access, edge placement, drive codes and blanking.
`timescale 1ns/1ps
`include "hcg_regs.vh"
module tb;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [47:0] horizontal_phase_one, horizontal_phase_two, horizontal_phase_three, horizontal_phase_four;
  logic [47:0] reset_gate_out_a, reset_gate_out_b, last_stage_horizontal_clock;
  logic [47:0] reference_sample_strobe, data_sample_strobe, prev, e;
  logic        odd_phase_oe, even_phase_oe, reset_gate_oe, last_stage_oe, horizontal_blanking, eb, pb;
  logic [3:0]  odd_phase_drive_code, even_phase_drive_code;
  logic [2:0]  reset_gate_drive_code, last_stage_drive_code;
  logic [15:0] pixel_count, shifts, s0, pc, d;
  logic [31:0] ew, sw;
  logic [31:0] rv [10] = '{32'h0, 32'h2000, 32'h1000, 32'h2000, 32'h20, 32'h0, 32'h0, 32'h0, 32'h0, 32'hFFF};
  logic [5:0]  rc [4] = '{6'h00, 6'h1B, 6'h2B, 6'h35};
  logic [5:0]  fc [4] = '{6'h3B, 6'h10, 6'h30, 6'h05};
  logic        iv [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  logic [15:0] dv [3] = '{16'h0000, 16'h7FFF, 16'h1520};
  int          n_mismatch = 0, samples_checked = 0, cyc = 0;

  always #4 aclk = ~aclk;

  hcg_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .horizontal_phase_one,
    .horizontal_phase_two, .horizontal_phase_three, .horizontal_phase_four, .reset_gate_out_a, .reset_gate_out_b,
    .last_stage_horizontal_clock, .reference_sample_strobe, .data_sample_strobe, .odd_phase_oe, .even_phase_oe,
    .reset_gate_oe, .last_stage_oe, .odd_phase_drive_code, .even_phase_drive_code, .reset_gate_drive_code,
    .last_stage_drive_code, .horizontal_blanking, .pixel_count);
  hcg_ccd_model ccd (.aclk, .phase_odd(horizontal_phase_one), .phase_odd_oe(odd_phase_oe), .shifts);

  task results();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end

  task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  function automatic int pos(input logic [5:0] c);
    return c[5:4] * 12 + c[3:0];
  endfunction

  // Fall before rise means the waveform starts the period high.
  function automatic logic [47:0] pat(input logic [5:0] r, input logic [5:0] f, input logic inv);
    logic [47:0] p;
    for (int k = 0; k < 48; k++) begin
      p[k] = (pos(r) < pos(f)) ? (k >= pos(r) && k < pos(f)) : (k >= pos(r) || k < pos(f));
    end
    return p ^ {48{inv}};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] dat, input logic [1:0] er);
    logic aw, w, b;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= dat;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge aclk);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid;
      if (b) chk({46'h0, s_axi_bresp}, {46'h0, er}, "write response");
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic ar, r;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    r = 1'b0;
    while (!r) begin
      @(negedge aclk);
      ar = s_axi_arvalid & s_axi_arready;
      r = s_axi_rvalid;
      if (r) chk({14'h0, s_axi_rresp, s_axi_rdata}, {14'h0, er, exp}, "read");
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask

  task automatic load();
    wr(`HCG_REG_LOAD, 32'h1, 2'h0);
    repeat (4) @(posedge aclk);
    @(negedge aclk);
  endtask

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 10; i++) rd(8'(4 * i), rv[i], 2'h0);
    rd(8'h30, 32'h0, 2'h2);
    wr(8'h34, 32'h1, 2'h2);
    prev = pat(6'h00, 6'h20, 1'b0);
    @(negedge aclk);
    chk(horizontal_phase_one, prev, "reset phase");
    chk(reference_sample_strobe, 48'h1 << pos(6'h20), "reset strobe");
    for (int i = 0; i < 4; i++) begin
      ew = {18'h0, fc[i], 2'h0, rc[i]};
      sw = {18'h0, rc[i], 2'h0, fc[i]};
      wr(`HCG_REG_CTRL, {30'h0, iv[i], iv[i]}, 2'h0);
      wr(`HCG_REG_ODD_EDGE, ew, 2'h0);
      wr(`HCG_REG_RG_EDGE, sw, 2'h0);
      wr(`HCG_REG_HL_EDGE, ew, 2'h0);
      wr(`HCG_REG_SAMPLE, ew, 2'h0);
      @(negedge aclk);
      chk(horizontal_phase_one, prev, "early update");
      load();
      e = pat(rc[i], fc[i], iv[i]);
      prev = e;
      chk(horizontal_phase_one, e, "phase one");
      chk(horizontal_phase_three, e, "phase three");
      chk(horizontal_phase_two, ~e, "phase two");
      chk(horizontal_phase_four, ~e, "phase four");
      chk(reset_gate_out_a, pat(fc[i], rc[i], iv[i]), "gate a");
      chk(reset_gate_out_b, pat(fc[i], rc[i], iv[i]), "gate b");
      chk(last_stage_horizontal_clock, pat(rc[i], fc[i], 1'b0), "last stage");
      chk(reference_sample_strobe, 48'h1 << pos(rc[i]), "ref strobe");
      chk(data_sample_strobe, 48'h1 << pos(fc[i]), "data strobe");
    end
    for (int i = 0; i < 3; i++) begin
      d = dv[i];
      wr(`HCG_REG_DRIVE, {16'h0, d}, 2'h0);
      load();
      s0 = shifts;
      chk({30'h0, odd_phase_oe, even_phase_oe, reset_gate_oe, last_stage_oe, odd_phase_drive_code,
        even_phase_drive_code, reset_gate_drive_code, last_stage_drive_code},
        {30'h0, |d[3:0], |d[7:4], |d[10:8], |d[14:12], d[3:0], d[7:4], d[10:8], d[14:12]}, "drive");
      repeat (8) @(negedge aclk);
      chk({32'h0, shifts - s0}, (d[3:0] != 4'h0) ? 48'h8 : 48'h0, "packets moved");
    end
    wr(`HCG_REG_LINE, 32'h0000_0027, 2'h0);
    wr(`HCG_REG_TOG0, {16'h0006, 16'h0003}, 2'h0);
    wr(`HCG_REG_TOG1, {16'h000C, 16'h000A}, 2'h0);
    wr(`HCG_REG_TOG2, {16'h0019, 16'h0014}, 2'h0);
    prev = pat(6'h35, 6'h05, 1'b0);
    for (int l = 0; l < 2; l++) begin
      wr(`HCG_REG_CTRL, {28'h0, 1'b1, l[0], 2'h0}, 2'h0);
      load();
      pb = 1'b0;
      repeat (90) begin
        @(negedge aclk);
        pc = pixel_count;
        eb = (pc > 3 && pc <= 6) || (pc > 10 && pc <= 12) || (pc > 20 && pc <= 25);
        chk({47'h0, horizontal_blanking}, {47'h0, eb}, "blanking");
        if (eb && pb) chk(horizontal_phase_one, {48{l[0]}}, "forced level");
        if (!eb && !pb) chk(horizontal_phase_one, prev, "free phase");
        pb = eb;
      end
    end
    results();
  end
endmodule // tb
